/* File: src/boot_lock_flash_protection.sv */
// Boot lock protection, reset vector and pointer latching for flash self-programming
//
// Contract
// - Lock bits only program; chip erase clears
// - General write-lock never blocks store path
// - General read/write-lock never blocks load/store
// - Stored 1 unprogrammed, 0 programmed
// - App locks 11: application unrestricted
// - App lower 0: stores to application refused
// - App upper 0: loader loads from app refused
// - App upper 0, vectors loader: app irqs off
// - Loader locks 11: loader section unrestricted
// - Loader lower 0: stores to loader refused
// - Loader upper 0: app loads from loader refused
// - Loader upper 0, vectors app: loader irqs off
// - Boot fuse 1: start at address zero
// - Boot fuse 0: start at loader start
// - Software has no fuse write path
// - Pointer is high byte and low byte
// - Low bits word in page, high bits page
// - Address latched when programming starts
// - Load uses pointer bit zero as byte select
// - One buffer word per store operation
// - Size fuses set section boundary
// - Store acts only from loader section
`timescale 1ns/1ns
module boot_lock_flash_protection #(
    parameter int PAGE_WORD_BITS = boot_lock_pkg::PAGE_WORD_BITS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Nonvolatile image and external programming interface
    input wire logic i_boot_reset_select_fuse,
    input wire logic [1:0] i_loader_size_fuses,
    input wire logic [3:0] i_lock_image,
    input wire logic i_chip_erase,
    input wire logic i_ext_lock_prog,
    input wire logic [3:0] i_ext_lock_data,
    // Core request
    input wire logic [14:0] i_pc,
    input wire logic i_req_valid,
    input wire boot_lock_pkg::core_req_t i_req,
    input wire logic i_vectors_in_loader,
    input wire logic i_prog_done,
    // Core answer
    output logic o_ready,
    output logic o_grant,
    output logic o_deny,
    output logic [14:0] o_load_word_addr,
    output logic o_load_byte_select,
    output logic o_irq_enable,
    output logic [14:0] o_reset_vector,
    // Programming engine
    output logic o_prog_start,
    output logic o_prog_busy,
    output boot_lock_pkg::prog_req_t o_prog,
    output logic [3:0] o_lock_bits
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG
    } prog_state_t;

    logic [1:0] rst_sync_q;
    logic rstn_q;
    logic boot_fuse_s1_q, boot_fuse_s2_q;
    logic [1:0] size_s1_q, size_s2_q;
    logic [3:0] image_s1_q, image_s2_q;
    logic erase_s1_q, erase_s2_q, erase_s3_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic [3:0] ext_data_s1_q, ext_data_s2_q;
    logic [1:0] load_cnt_q;
    logic ready_q;
    logic boot_fuse_q;
    logic [1:0] size_fuses_q;
    boot_lock_pkg::lock_bits_t lock_q;
    prog_state_t state_q;
    logic erase_evt, ext_evt;
    logic [15:0] ptr;
    logic [14:0] tgt_word;
    logic pc_in_loader, tgt_in_loader;
    logic [14:0] loader_start;
    logic store_ok, load_ok, lock_ok;
    logic req_store, req_load, req_lock;
    logic irq_en_d;

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn_q = rst_sync_q[1];

    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            boot_fuse_s1_q <= 1'b0;
            boot_fuse_s2_q <= 1'b0;
            size_s1_q <= 2'h0;
            size_s2_q <= 2'h0;
            image_s1_q <= 4'h0;
            image_s2_q <= 4'h0;
        end else begin
            boot_fuse_s1_q <= i_boot_reset_select_fuse;
            boot_fuse_s2_q <= boot_fuse_s1_q;
            size_s1_q <= i_loader_size_fuses;
            size_s2_q <= size_s1_q;
            image_s1_q <= i_lock_image;
            image_s2_q <= image_s1_q;
        end
    end

    // Programming-interface strobes, edge found after the second stage
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            erase_s1_q <= 1'b0;
            erase_s2_q <= 1'b0;
            erase_s3_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_data_s1_q <= 4'h0;
            ext_data_s2_q <= 4'h0;
        end else begin
            erase_s1_q <= i_chip_erase;
            erase_s2_q <= erase_s1_q;
            erase_s3_q <= erase_s2_q;
            ext_s1_q <= i_ext_lock_prog;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_data_s1_q <= i_ext_lock_data;
            ext_data_s2_q <= ext_data_s1_q;
        end
    end
    assign erase_evt = erase_s2_q && !erase_s3_q;
    assign ext_evt = ext_s2_q && !ext_s3_q;

    // Image is caught once the synchronisers hold settled values
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            load_cnt_q <= 2'h0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            load_cnt_q <= 2'(load_cnt_q + 2'h1);
            ready_q <= (load_cnt_q == 2'(boot_lock_pkg::LOAD_WAIT_CYCLES - 1));
        end
    end

    // Fuses are sampled every cycle after reset until ready and then held
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            boot_fuse_q <= boot_lock_pkg::BOOT_FUSE_RESET;
            size_fuses_q <= boot_lock_pkg::SIZE_FUSE_RESET;
        end else if (!ready_q) begin
            boot_fuse_q <= boot_fuse_s2_q;
            size_fuses_q <= size_s2_q;
        end
    end

    assign ptr = {i_req.flash_pointer_high, i_req.flash_pointer_low};
    assign tgt_word = ptr[15:1];

    section_decode #(
        .ADDR_W(boot_lock_pkg::FLASH_WORD_BITS)
    ) u_pc_section (
        .i_addr(i_pc),
        .i_size_fuses(size_fuses_q),
        .o_in_loader(pc_in_loader),
        .o_loader_start(loader_start)
    );

    section_decode #(
        .ADDR_W(boot_lock_pkg::FLASH_WORD_BITS)
    ) u_tgt_section (
        .i_addr(tgt_word),
        .i_size_fuses(size_fuses_q),
        .o_in_loader(tgt_in_loader),
        .o_loader_start()
    );

    assign req_store = i_req_valid && ready_q && (i_req.kind == boot_lock_pkg::OP_STORE);
    assign req_load = i_req_valid && ready_q && (i_req.kind == boot_lock_pkg::OP_LOAD);
    assign req_lock = i_req_valid && ready_q && (i_req.kind == boot_lock_pkg::OP_LOCK_SET);

    // General lock bits are not consulted here
    // A lock bit of 1 restricts nothing
    assign store_ok = pc_in_loader && (state_q == ST_IDLE) &&
        (tgt_in_loader ? lock_q.loader_lock_lower : lock_q.app_lock_lower);
    assign load_ok = (pc_in_loader == tgt_in_loader) ||
        (pc_in_loader ? lock_q.app_lock_upper : lock_q.loader_lock_upper);
    assign lock_ok = pc_in_loader && (state_q == ST_IDLE);

    // Once the image is loaded, lock bits move to 0 only; erase restores 1
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            lock_q <= boot_lock_pkg::LOCK_RESET;
        end else if (!ready_q) begin
            lock_q <= image_s2_q;
        end else if (erase_evt) begin
            lock_q <= boot_lock_pkg::LOCK_ERASED;
        end else begin
            lock_q <= lock_q
                & (ext_evt ? ext_data_s2_q : 4'hF)
                & ((req_lock && lock_ok) ?
                i_req.data[boot_lock_pkg::LOCK_DATA_LSB +: boot_lock_pkg::LOCK_BITS] : 4'hF);
        end
    end

    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_store && store_ok) begin
                        state_q <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    if (i_prog_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Latch page, word and one data word
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            o_prog <= '0;
            o_prog_start <= 1'b0;
        end else begin
            o_prog_start <= req_store && store_ok;
            if (req_store && store_ok) begin
                o_prog.page <= ptr[15:PAGE_WORD_BITS+1];
                o_prog.word <= ptr[PAGE_WORD_BITS:1];
                o_prog.data <= i_req.data;
            end
        end
    end
    assign o_prog_busy = (state_q == ST_PROG);

    // Byte select from pointer bit zero
    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            o_grant <= 1'b0;
            o_deny <= 1'b0;
            o_load_word_addr <= 15'h0000;
            o_load_byte_select <= 1'b0;
        end else begin
            o_grant <= (req_store && store_ok) || (req_load && load_ok) ||
                (req_lock && lock_ok);
            o_deny <= (req_store && !store_ok) || (req_load && !load_ok) ||
                (req_lock && !lock_ok);
            if (req_load && load_ok) begin
                o_load_word_addr <= tgt_word;
                o_load_byte_select <= ptr[0];
            end
        end
    end

    assign irq_en_d =
        !(!lock_q.app_lock_upper && i_vectors_in_loader && !pc_in_loader) &&
        !(!lock_q.loader_lock_upper && !i_vectors_in_loader && pc_in_loader);

    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            o_irq_enable <= 1'b0;
            o_reset_vector <= boot_lock_pkg::APP_RESET_ADDR;
        end else begin
            o_irq_enable <= ready_q && irq_en_d;
            o_reset_vector <= boot_fuse_q ? boot_lock_pkg::APP_RESET_ADDR : loader_start;
        end
    end

    assign o_ready = ready_q;
    assign o_lock_bits = lock_q;

    // Checks

    chk_store_from_app: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_store && !pc_in_loader |=> !o_prog_start && o_deny)
        else $error("store from application section started programming");

    chk_app_write_lock: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_store && !tgt_in_loader && !lock_q.app_lock_lower |=> o_deny && !o_grant)
        else $error("store into write-locked application section allowed");

    chk_loader_write_lock: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_store && tgt_in_loader && !lock_q.loader_lock_lower |=> !o_prog_start)
        else $error("store into write-locked loader section allowed");

    chk_load_app_guard: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_load && pc_in_loader && !tgt_in_loader && !lock_q.app_lock_upper
        |=> o_deny)
        else $error("loader read of read-locked application section");

    chk_load_loader_guard: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_load && !pc_in_loader && tgt_in_loader && !lock_q.loader_lock_upper
        |=> o_deny)
        else $error("application read of read-locked loader section");

    chk_irq_app_gate: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        !lock_q.app_lock_upper && i_vectors_in_loader && !pc_in_loader
        |=> !o_irq_enable)
        else $error("interrupt left enabled in locked application section");

    chk_irq_loader_gate: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        !lock_q.loader_lock_upper && !i_vectors_in_loader && pc_in_loader
        |=> !o_irq_enable)
        else $error("interrupt left enabled in locked loader section");

    chk_reset_vector: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        ready_q && $stable(boot_fuse_q) ##1 ready_q
        |-> o_reset_vector == (boot_fuse_q ? 15'h0000 : loader_start))
        else $error("reset vector does not follow boot fuse");

    chk_addr_hold: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        o_prog_busy && $past(o_prog_busy) && !o_prog_start |-> $stable(o_prog))
        else $error("latched programming address moved while busy");

    chk_lock_one_way: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        ready_q && $past(ready_q) && ((lock_q & ~$past(lock_q)) != 4'h0)
        |-> $past(erase_evt))
        else $error("lock bit returned to unprogrammed without chip erase");

    chk_byte_select: assert property (
        @(posedge i_clk) disable iff (!rstn_q)
        req_load && load_ok |=> o_load_byte_select == $past(ptr[0]) &&
        o_load_word_addr == $past(tgt_word))
        else $error("load address or byte select wrong");

endmodule

/* File: src/boot_lock_pkg.sv */
// Shared constants, types and section helpers for the flash protection block
package boot_lock_pkg;

    localparam int FLASH_WORD_BITS = 15;
    localparam int PTR_BITS = 16;
    localparam int PAGE_WORD_BITS = 7;
    localparam int LOCK_BITS = 4;
    localparam int SYNC_STAGES = 2;
    localparam int LOAD_WAIT_CYCLES = 3;

    localparam logic [14:0] APP_RESET_ADDR = 15'h0000;
    localparam logic [14:0] FLASH_TOP_WORDS = 15'h7FFF;
    // Loader size per size-fuse code; 1 means unprogrammed
    localparam logic [14:0] LOADER_WORDS_CODE3 = 15'h0200;
    localparam logic [14:0] LOADER_WORDS_CODE2 = 15'h0400;
    localparam logic [14:0] LOADER_WORDS_CODE1 = 15'h0800;
    localparam logic [14:0] LOADER_WORDS_CODE0 = 15'h1000;

    // Until the lock image is loaded everything counts as programmed
    localparam logic [3:0] LOCK_RESET = 4'h0;
    localparam logic [3:0] LOCK_ERASED = 4'hF;
    localparam logic [1:0] SIZE_FUSE_RESET = 2'h0;
    localparam logic BOOT_FUSE_RESET = 1'b0;
    // Position of the lock field inside the store data word
    localparam int LOCK_DATA_LSB = 2;

    typedef enum logic [1:0] {
        OP_LOAD,
        OP_STORE,
        OP_LOCK_SET,
        OP_NONE
    } op_kind_t;

    typedef struct packed {
        logic loader_lock_upper;
        logic loader_lock_lower;
        logic app_lock_upper;
        logic app_lock_lower;
    } lock_bits_t;

    typedef struct packed {
        op_kind_t kind;
        logic [7:0] flash_pointer_high;
        logic [7:0] flash_pointer_low;
        logic [15:0] data;
    } core_req_t;

    typedef struct packed {
        logic [FLASH_WORD_BITS-PAGE_WORD_BITS-1:0] page;
        logic [PAGE_WORD_BITS-1:0] word;
        logic [15:0] data;
    } prog_req_t;

    function automatic logic [14:0] loader_start_f(input logic [1:0] size_fuses);
        logic [14:0] words;
        words = LOADER_WORDS_CODE3;
        case (size_fuses)
            2'h3: words = LOADER_WORDS_CODE3;
            2'h2: words = LOADER_WORDS_CODE2;
            2'h1: words = LOADER_WORDS_CODE1;
            default: words = LOADER_WORDS_CODE0;
        endcase
        return 15'(FLASH_TOP_WORDS - words + 15'h0001);
    endfunction

endpackage

/* File: src/section_decode.sv */
// Decides whether a program-word address lies in the loader section
`timescale 1ns/1ns
module section_decode #(
    parameter int ADDR_W = 15
) (
    // Address under test
    input wire logic [ADDR_W-1:0] i_addr,
    // Loader size fuses
    input wire logic [1:0] i_size_fuses,
    // Result
    output logic o_in_loader,
    output logic [ADDR_W-1:0] o_loader_start
);

    assign o_loader_start = ADDR_W'(boot_lock_pkg::loader_start_f(i_size_fuses));
    assign o_in_loader = (i_addr >= o_loader_start);

endmodule

/* File: tb/boot_lock_flash_protection_test.sv */
// Self-checking testbench for the flash protection block
`timescale 1ns/1ns
module boot_lock_flash_protection_test;
    localparam logic [14:0] APP_PC = 15'h0100;
    localparam logic [14:0] BL_PC = 15'h7E10;
    localparam logic [1:0] G = 2'b10;
    localparam logic [1:0] D = 2'b01;
    logic i_clk, i_rstn, i_boot_reset_select_fuse, i_chip_erase, i_ext_lock_prog;
    logic i_vectors_in_loader, i_req_valid, i_prog_done;
    logic [1:0] i_loader_size_fuses;
    logic [3:0] i_lock_image, i_ext_lock_data, o_lock_bits;
    logic [14:0] i_pc, o_load_word_addr, o_reset_vector, exp15;
    boot_lock_pkg::core_req_t i_req;
    boot_lock_pkg::prog_req_t o_prog;
    logic o_ready, o_grant, o_deny, o_load_byte_select, o_irq_enable;
    logic o_prog_start, o_prog_busy;
    logic [14:0] sizes [4];
    int n_mismatch = 0;
    int cmp_count = 0;

    boot_lock_flash_protection boot_lock_flash_protection_inst (.i_clk(i_clk),
        .i_rstn(i_rstn), .i_boot_reset_select_fuse(i_boot_reset_select_fuse),
        .i_loader_size_fuses(i_loader_size_fuses), .i_lock_image(i_lock_image),
        .i_chip_erase(i_chip_erase), .i_ext_lock_prog(i_ext_lock_prog),
        .i_ext_lock_data(i_ext_lock_data), .i_pc(i_pc), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_vectors_in_loader(i_vectors_in_loader),
        .i_prog_done(i_prog_done), .o_ready(o_ready), .o_grant(o_grant),
        .o_deny(o_deny), .o_load_word_addr(o_load_word_addr),
        .o_load_byte_select(o_load_byte_select), .o_irq_enable(o_irq_enable),
        .o_reset_vector(o_reset_vector), .o_prog_start(o_prog_start),
        .o_prog_busy(o_prog_busy), .o_prog(o_prog), .o_lock_bits(o_lock_bits));

    core_model core_model_inst (.i_clk(i_clk), .i_grant(o_grant), .i_deny(o_deny),
        .i_prog_start(o_prog_start), .o_pc(i_pc), .o_req_valid(i_req_valid),
        .o_req(i_req), .o_prog_done(i_prog_done));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [15:0] exp,
                             input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic req(input boot_lock_pkg::op_kind_t kind, input logic [14:0] pc,
                       input logic [15:0] ptr, input logic [15:0] data,
                       input logic [1:0] exp);
        logic [1:0] ans;
        core_model_inst.issue(kind, pc, ptr, data, ans);
        check_val("grant/deny answer", {14'h0000, exp}, {14'h0000, ans});
    endtask

    // Fuses and image must stand still while start-up captures them
    task automatic do_reset(input logic boot, input logic [1:0] size);
        @(negedge i_clk);
        i_rstn = 1'b0;
        i_boot_reset_select_fuse = boot;
        i_loader_size_fuses = size;
        repeat (16) @(negedge i_clk);
        i_rstn = 1'b1;
        for (int n = 0; n < 20 && o_ready !== 1'b1; n++) @(negedge i_clk);
        check_val("ready after reset", 16'h0001, {15'h0000, o_ready});
        if (o_ready !== 1'b1) final_report();
        // Reset vector register takes the captured fuses one cycle after ready
        @(negedge i_clk);
    endtask

    task automatic wait_locks(input logic [3:0] exp);
        for (int n = 0; n < 8 && o_lock_bits !== exp; n++) @(negedge i_clk);
        check_val("lock bits", {12'h000, exp}, {12'h000, o_lock_bits});
        if (o_lock_bits !== exp) final_report();
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 40 && o_prog_busy !== 1'b0; n++) @(negedge i_clk);
        check_val("busy released", 16'h0000, {15'h0000, o_prog_busy});
        if (o_prog_busy !== 1'b0) final_report();
    endtask

    task automatic check_irq(input logic [14:0] pc, input logic exp);
        core_model_inst.set_pc(pc);
        repeat (2) @(negedge i_clk);
        check_val("irq enable", {15'h0000, exp}, {15'h0000, o_irq_enable});
    endtask

    initial begin
        sizes = '{boot_lock_pkg::LOADER_WORDS_CODE0, boot_lock_pkg::LOADER_WORDS_CODE1,
                  boot_lock_pkg::LOADER_WORDS_CODE2, boot_lock_pkg::LOADER_WORDS_CODE3};
        i_rstn = 1'b0;
        i_boot_reset_select_fuse = 1'b1;
        i_loader_size_fuses = 2'h3;
        i_lock_image = 4'hF;
        i_chip_erase = 1'b0;
        i_ext_lock_prog = 1'b0;
        i_ext_lock_data = 4'hF;
        i_vectors_in_loader = 1'b0;
        for (int c = 0; c < 4; c++) begin
            do_reset(1'b0, 2'(c));
            exp15 = 15'h0000 - sizes[c];
            check_val("loader reset vector", {1'b0, exp15}, {1'b0, o_reset_vector});
        end
        do_reset(1'b1, 2'h3);
        check_val("app reset vector", 16'h0000, {1'b0, o_reset_vector});
        wait_locks(4'hF);
        i_boot_reset_select_fuse = 1'b0;
        repeat (4) @(negedge i_clk);
        check_val("vector after fuse pin change", 16'h0000, {1'b0, o_reset_vector});
        req(boot_lock_pkg::OP_LOAD, APP_PC, 16'h1235, 16'h0000, G);
        check_val("load word address", 16'h091A, {1'b0, o_load_word_addr});
        check_val("byte select", 16'h0001, {15'h0000, o_load_byte_select});
        req(boot_lock_pkg::OP_STORE, APP_PC, 16'hFD57, 16'hBEEF, D);
        core_model_inst.done_delay = 20;
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'hFD57, 16'hBEEF, G);
        check_val("prog start", 16'h0001, {15'h0000, o_prog_start});
        check_val("busy", 16'h0001, {15'h0000, o_prog_busy});
        check_val("page", 16'h00FD, {8'h00, o_prog.page});
        check_val("word in page", 16'h002B, {9'h000, o_prog.word});
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'h0400, 16'h1111, D);
        req(boot_lock_pkg::OP_LOAD, BL_PC, 16'h0400, 16'h0000, G);
        check_val("latched page", 16'h00FD, {8'h00, o_prog.page});
        check_val("latched data", 16'hBEEF, o_prog.data);
        wait_idle();
        core_model_inst.done_delay = 1;
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'h0400, 16'h2222, G);
        wait_idle();
        req(boot_lock_pkg::OP_LOCK_SET, BL_PC, 16'h0001, 16'h0038, G);
        wait_locks(4'hE);
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'h0400, 16'h3333, D);
        req(boot_lock_pkg::OP_LOAD, BL_PC, 16'h0400, 16'h0000, G);
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'hFC00, 16'h4444, G);
        wait_idle();
        req(boot_lock_pkg::OP_LOCK_SET, APP_PC, 16'h0001, 16'h0000, D);
        req(boot_lock_pkg::OP_LOCK_SET, BL_PC, 16'h0001, 16'h0030, G);
        wait_locks(4'hC);
        req(boot_lock_pkg::OP_LOAD, BL_PC, 16'h0400, 16'h0000, D);
        req(boot_lock_pkg::OP_LOAD, APP_PC, 16'h0400, 16'h0000, G);
        i_vectors_in_loader = 1'b1;
        check_irq(APP_PC, 1'b0);
        check_irq(BL_PC, 1'b1);
        req(boot_lock_pkg::OP_LOCK_SET, BL_PC, 16'h0001, 16'h003C, G);
        wait_locks(4'hC);
        @(negedge i_clk);
        i_ext_lock_data = 4'h3;
        i_ext_lock_prog = 1'b1;
        repeat (2) @(negedge i_clk);
        i_ext_lock_prog = 1'b0;
        wait_locks(4'h0);
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'hFC00, 16'h5555, D);
        req(boot_lock_pkg::OP_LOAD, APP_PC, 16'hFC00, 16'h0000, D);
        i_vectors_in_loader = 1'b0;
        check_irq(BL_PC, 1'b0);
        check_irq(APP_PC, 1'b1);
        @(negedge i_clk);
        i_chip_erase = 1'b1;
        repeat (2) @(negedge i_clk);
        i_chip_erase = 1'b0;
        wait_locks(4'hF);
        req(boot_lock_pkg::OP_STORE, BL_PC, 16'hFC00, 16'h6666, G);
        wait_idle();
        final_report();
    end
endmodule

/* File: tb/core_model.sv */
// Core-side model: issues flash requests and plays the programming engine
`timescale 1ns/1ns
module core_model (
    // Clock
    input wire logic i_clk,
    // Answers from the protection block
    input wire logic i_grant,
    input wire logic i_deny,
    input wire logic i_prog_start,
    // Requests to the protection block
    output logic [14:0] o_pc,
    output logic o_req_valid,
    output boot_lock_pkg::core_req_t o_req,
    output logic o_prog_done
);
    int done_delay = 2;

    initial begin
        o_pc = 15'h0000;
        o_req_valid = 1'b0;
        o_req = '0;
        o_prog_done = 1'b0;
    end

    // One buffer word per granted store
    // Page order is left to the caller; the model never reorders
    always begin
        @(negedge i_clk);
        if (i_prog_start === 1'b1) begin
            repeat (done_delay) @(negedge i_clk);
            o_prog_done = 1'b1;
            @(negedge i_clk);
            o_prog_done = 1'b0;
        end
    end

    task automatic set_pc(input logic [14:0] pc);
        @(negedge i_clk);
        o_pc = pc;
    endtask

    // One-cycle request; returns {grant, deny}, 00 if no answer came
    task automatic issue(input boot_lock_pkg::op_kind_t kind, input logic [14:0] pc,
                         input logic [15:0] ptr, input logic [15:0] data,
                         output logic [1:0] ans);
        @(negedge i_clk);
        o_pc = pc;
        o_req = {kind, ptr, data};
        o_req_valid = 1'b1;
        @(negedge i_clk);
        o_req_valid = 1'b0;
        // Released fields flip so a stale value is never mistaken for a hold
        o_req = ~o_req;
        ans = 2'b00;
        for (int n = 0; n < 3 && ans === 2'b00; n++) begin
            ans = {i_grant, i_deny};
            if (ans === 2'b00) @(negedge i_clk);
        end
    endtask
endmodule
